// ===== hw/bcc_decode.sv
// Decodes voltage and current codes into millivolts and milliamps
`timescale 1ns/1ps
module bcc_decode (
  input  wire logic [3:0]  vsel,
  input  wire logic [2:0]  ilim,
  output logic      [11:0] target_mv,
  output logic      [9:0]  limit_ma
);

  localparam logic [11:0] MV_PLACEHOLDER = 12'h000;

  function automatic logic [11:0] vsel_to_mv(input logic [3:0] code);
    logic [11:0] mv;
    mv = MV_PLACEHOLDER;
    if (code <= bcc_pkg::VSEL_LINEAR_MAX) begin
      mv = 12'(bcc_pkg::MV_BASE + bcc_pkg::MV_STEP * {8'h00, code});
    end else if (code == bcc_pkg::VSEL_CODE_3V3) begin
      mv = bcc_pkg::MV_3V3;
    end else begin
      mv = bcc_pkg::MV_3V5;
    end
    return mv;
  endfunction

  // Reserved codes report no limit
  function automatic logic [9:0] ilim_to_ma(input logic [2:0] code);
    logic [9:0] ma;
    ma = bcc_pkg::MA_NONE;
    if (code >= bcc_pkg::ILIM_MIN && code <= bcc_pkg::ILIM_MAX) begin
      ma = 10'(bcc_pkg::MA_STEP * ({7'h00, code} + 10'h001));
    end
    return ma;
  endfunction

  always_comb begin
    target_mv = vsel_to_mv(vsel);
    limit_ma  = ilim_to_ma(ilim);
  end

endmodule

// ===== hw/bcc_pkg.sv
// Buck converter register bank: shared constants and carrier types
package bcc_pkg;

  // Paged register space location
  localparam logic [7:0] SFR_PAGE      = 8'h02;
  localparam logic [7:0] ADDR_CONFIG   = 8'hb2;
  localparam logic [7:0] ADDR_MODE     = 8'hb3;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // Reset values
  localparam logic [7:0] CONFIG_RESET  = 8'h0b;
  localparam logic [7:0] MODE_RESET    = 8'h42;

  // Configuration field positions
  localparam int CFG_BYPASS_BIT = 7;
  localparam int CFG_VSEL_HI    = 6;
  localparam int CFG_VSEL_LO    = 3;
  localparam int CFG_OSC_BIT    = 2;
  localparam int CFG_SW_HI      = 1;
  localparam int CFG_SW_LO      = 0;

  // Mode field positions and fixed reserved bits
  localparam int MODE_RSV_HI_BIT = 7;
  localparam int MODE_ILIM_HI    = 6;
  localparam int MODE_ILIM_LO    = 4;
  localparam int MODE_FORCED_BIT = 3;
  localparam int MODE_AUTO_BIT   = 2;
  localparam int MODE_RSV_LO_BIT = 1;
  localparam int MODE_EN_BIT     = 0;
  localparam logic MODE_RSV_HI_VAL = 1'b0;
  localparam logic MODE_RSV_LO_VAL = 1'b1;

  // Switch size and peak current codes
  localparam logic [1:0] SW_MIN   = 2'b00;
  localparam logic [1:0] SW_MAX   = 2'b11;
  localparam logic [2:0] ILIM_MIN = 3'h1;
  localparam logic [2:0] ILIM_MAX = 3'h5;

  // Target voltage map, in millivolts
  localparam logic [3:0]  VSEL_LINEAR_MAX = 4'hd;
  localparam logic [3:0]  VSEL_CODE_3V3   = 4'he;
  localparam logic [11:0] MV_BASE         = 12'h708;
  localparam logic [11:0] MV_STEP         = 12'h064;
  localparam logic [11:0] MV_3V3          = 12'hce4;
  localparam logic [11:0] MV_3V5          = 12'hdac;

  // Peak current map, in milliamps
  localparam logic [9:0] MA_STEP = 10'h064;
  localparam logic [9:0] MA_NONE = 10'h000;

  typedef struct packed {
    logic [7:0] page;
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } bcc_sfr_req_type;

  typedef struct packed {
    logic [3:0] vsel;
    logic       osc_disable;
    logic [1:0] swsel;
  } bcc_cfg_type;

  typedef struct packed {
    logic [2:0] ilim;
    logic       forced;
    logic       autob;
    logic       enable;
  } bcc_mode_type;

endpackage

// ===== hw/bcc_regs.sv
// Buck converter configuration and mode registers in paged SFR space
`timescale 1ns/1ps
// Behaviour
// - Configuration bit 7 is read-only and shows 1 while the bypass switch is closed.
// - Configuration bits 6:3 select the target, 0000 is 1.8 V, 0001 is 1.9 V, 0111 is 2.5 V.
// - Codes 1000 to 1101 give 2.6 V to 3.1 V, 1110 gives 3.3 V and 1111 gives 3.5 V.
// - Configuration bit 2 set to 1 disables the converter's local oscillator.
// - Bits 1:0 pick minimum (00) or maximum (11) switches, 01 and 10 are reserved, reset 11.
// - Mode bits 6:4 limit peak current, 001 is 200 mA rising by 100 mA to 600 mA at 101.
// - Mode bit 3 enables forced bypass.
// - Mode bit 2 enables automatic bypass.
// - Mode bit 0 turns the converter on.
module bcc_regs (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire bcc_pkg::bcc_sfr_req_type sfr_req,
  output logic      [7:0]               sfr_rdata,
  output logic                          sfr_rvalid,
  input  wire logic                     bypass_switch_closed,
  output logic                          converter_enable,
  output logic                          forced_bypass_enable,
  output logic                          automatic_bypass_enable,
  output logic      [2:0]               peak_current_limit,
  output logic      [3:0]               output_voltage_select,
  output logic                          oscillator_disable,
  output logic      [1:0]               switch_size_select,
  output logic      [11:0]              target_mv,
  output logic      [9:0]               current_limit_ma
);

  bcc_pkg::bcc_cfg_type  cfg_ff;
  bcc_pkg::bcc_cfg_type  nxt_cfg;
  bcc_pkg::bcc_mode_type mode_ff;
  bcc_pkg::bcc_mode_type nxt_mode;
  logic [7:0]            rdata_ff;
  logic [7:0]            nxt_rdata;
  logic                  rvalid_ff;
  logic                  nxt_rvalid;
  logic [11:0]           mv_ff;
  logic [11:0]           nxt_mv;
  logic [9:0]            ma_ff;
  logic [9:0]            nxt_ma;
  logic                  bypass_sync;
  logic                  hit_page;
  logic                  wr_cfg;
  logic                  wr_mode;
  logic                  rd_cfg;
  logic                  rd_mode;
  logic [1:0]            wr_sw;
  logic [2:0]            wr_ilim;
  logic [7:0]            cfg_view;
  logic [7:0]            mode_view;
  logic [11:0]           dec_mv;
  logic [9:0]            dec_ma;

  // Pin comes from the analogue side, so synchronise first
  // indicator from pin
  bcc_sync u_bypass_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in (bypass_switch_closed),
    .sync_out (bypass_sync)
  );

  bcc_decode u_decode (
    .vsel      (cfg_ff.vsel),
    .ilim      (mode_ff.ilim),
    .target_mv (dec_mv),
    .limit_ma  (dec_ma)
  );

  always_comb begin
    hit_page = (sfr_req.page == bcc_pkg::SFR_PAGE);
    wr_cfg   = hit_page && sfr_req.wr && (sfr_req.addr == bcc_pkg::ADDR_CONFIG);
    wr_mode  = hit_page && sfr_req.wr && (sfr_req.addr == bcc_pkg::ADDR_MODE);
    rd_cfg   = hit_page && sfr_req.rd && (sfr_req.addr == bcc_pkg::ADDR_CONFIG);
    rd_mode  = hit_page && sfr_req.rd && (sfr_req.addr == bcc_pkg::ADDR_MODE);
    wr_sw    = sfr_req.wdata[bcc_pkg::CFG_SW_HI:bcc_pkg::CFG_SW_LO];
    wr_ilim  = sfr_req.wdata[bcc_pkg::MODE_ILIM_HI:bcc_pkg::MODE_ILIM_LO];
  end

  always_comb begin
    cfg_view = {bypass_sync, cfg_ff.vsel, cfg_ff.osc_disable, cfg_ff.swsel};
    mode_view = {bcc_pkg::MODE_RSV_HI_VAL, mode_ff.ilim, mode_ff.forced,
                 mode_ff.autob, bcc_pkg::MODE_RSV_LO_VAL, mode_ff.enable};
  end

  // Register update
  always_comb begin
    nxt_cfg  = cfg_ff;
    nxt_mode = mode_ff;
    if (wr_cfg) begin
      nxt_cfg.vsel        = sfr_req.wdata[bcc_pkg::CFG_VSEL_HI:bcc_pkg::CFG_VSEL_LO];
      nxt_cfg.osc_disable = sfr_req.wdata[bcc_pkg::CFG_OSC_BIT];
      // reserved sizes never reach the switches
      if (wr_sw == bcc_pkg::SW_MIN || wr_sw == bcc_pkg::SW_MAX) begin
        nxt_cfg.swsel = wr_sw;
      end
    end
    if (wr_mode) begin
      // reserved limits keep the last legal code
      if (wr_ilim >= bcc_pkg::ILIM_MIN && wr_ilim <= bcc_pkg::ILIM_MAX) begin
        nxt_mode.ilim = wr_ilim;
      end
      nxt_mode.forced = sfr_req.wdata[bcc_pkg::MODE_FORCED_BIT];
      nxt_mode.autob  = sfr_req.wdata[bcc_pkg::MODE_AUTO_BIT];
      nxt_mode.enable = sfr_req.wdata[bcc_pkg::MODE_EN_BIT];
    end
  end

  // Read port, data valid the cycle after the strobe
  always_comb begin
    nxt_rvalid = sfr_req.rd;
    nxt_rdata  = rdata_ff;
    if (rd_cfg) begin
      nxt_rdata = cfg_view;
    end else if (rd_mode) begin
      // bit 7 reads zero and bit 1 reads one
      nxt_rdata = mode_view;
    end else if (sfr_req.rd) begin
      nxt_rdata = bcc_pkg::READ_UNMAPPED;
    end
  end

  // decoded targets registered for clean outputs
  always_comb begin
    nxt_mv = dec_mv;
    nxt_ma = dec_ma;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_ff    <= bcc_pkg::bcc_cfg_type'(bcc_pkg::CONFIG_RESET[bcc_pkg::CFG_VSEL_HI:0]);
      mode_ff   <= '{ilim:   bcc_pkg::MODE_RESET[bcc_pkg::MODE_ILIM_HI:bcc_pkg::MODE_ILIM_LO],
                     forced: bcc_pkg::MODE_RESET[bcc_pkg::MODE_FORCED_BIT],
                     autob:  bcc_pkg::MODE_RESET[bcc_pkg::MODE_AUTO_BIT],
                     enable: bcc_pkg::MODE_RESET[bcc_pkg::MODE_EN_BIT]};
      rdata_ff  <= bcc_pkg::READ_UNMAPPED;
      rvalid_ff <= 1'b0;
      mv_ff     <= bcc_pkg::MV_BASE;
      ma_ff     <= bcc_pkg::MA_NONE;
    end else begin
      cfg_ff    <= nxt_cfg;
      mode_ff   <= nxt_mode;
      rdata_ff  <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
      mv_ff     <= nxt_mv;
      ma_ff     <= nxt_ma;
    end
  end

  assign sfr_rdata               = rdata_ff;
  assign sfr_rvalid              = rvalid_ff;
  assign converter_enable        = mode_ff.enable;
  assign forced_bypass_enable    = mode_ff.forced;
  assign automatic_bypass_enable = mode_ff.autob;
  assign peak_current_limit      = mode_ff.ilim;
  assign output_voltage_select   = cfg_ff.vsel;
  assign oscillator_disable      = cfg_ff.osc_disable;
  assign switch_size_select      = cfg_ff.swsel;
  assign target_mv               = mv_ff;
  assign current_limit_ma        = ma_ff;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence cfg_write_s(logic [3:0] code);
    wr_cfg && (sfr_req.wdata[bcc_pkg::CFG_VSEL_HI:bcc_pkg::CFG_VSEL_LO] == code);
  endsequence

  sequence cfg_read_s;
    rd_cfg;
  endsequence

  sequence switch_held_s;
    bypass_switch_closed [*3];
  endsequence

  bypass_read_a: assert property (
    cfg_read_s |=> (sfr_rdata[bcc_pkg::CFG_BYPASS_BIT] == $past(bypass_sync)) && sfr_rvalid)
    else $error("bypass indicator does not match switch");

  vsel_low_a: assert property (
    cfg_write_s(4'h0) |=> (output_voltage_select == 4'h0) ##1 (target_mv == 12'h708))
    else $error("code zero does not give 1.8 V");

  // top codes give 3.3 V and 3.5 V
  vsel_top_a: assert property (
    (output_voltage_select >= bcc_pkg::VSEL_CODE_3V3) |=>
      (target_mv == (($past(output_voltage_select) == 4'he) ? 12'hce4 : 12'hdac)))
    else $error("top voltage codes decode wrongly");

  // linear codes step by 0.1 V
  vsel_step_a: assert property (
    (output_voltage_select <= bcc_pkg::VSEL_LINEAR_MAX) |=>
      (target_mv == 12'(12'd1800 + 12'd100 * {8'h00, $past(output_voltage_select)})))
    else $error("linear voltage step wrong");

  // oscillator disable follows the written bit
  osc_disable_a: assert property (
    wr_cfg |=> oscillator_disable == $past(sfr_req.wdata[bcc_pkg::CFG_OSC_BIT]))
    else $error("oscillator disable not stored");

  // only legal switch sizes ever drive the converter
  switch_size_a: assert property (
    (switch_size_select == 2'b00) || (switch_size_select == 2'b11))
    else $error("reserved switch size reached output");

  switch_hold_a: assert property (
    (wr_cfg && (wr_sw == 2'b01 || wr_sw == 2'b10)) |=> $stable(switch_size_select))
    else $error("reserved switch size write changed setting");

  // current limit steps of 100 mA from 200 mA
  ilim_map_a: assert property (
    (peak_current_limit >= 3'h1 && peak_current_limit <= 3'h5) |=>
      (current_limit_ma == 10'(10'd100 * ({7'h00, $past(peak_current_limit)} + 10'd1))))
    else $error("peak current limit decode wrong");

  // forced bypass follows the written bit
  forced_a: assert property (
    wr_mode |=> forced_bypass_enable == $past(sfr_req.wdata[bcc_pkg::MODE_FORCED_BIT]))
    else $error("forced bypass not stored");

  // automatic bypass follows the written bit
  auto_a: assert property (
    wr_mode |=> automatic_bypass_enable == $past(sfr_req.wdata[bcc_pkg::MODE_AUTO_BIT]))
    else $error("automatic bypass not stored");

  // enable follows the written bit and holds otherwise
  enable_a: assert property (
    (!wr_mode) |=> $stable(converter_enable))
    else $error("converter enable changed without write");

  enable_write_a: assert property (
    wr_mode |=> converter_enable == $past(sfr_req.wdata[bcc_pkg::MODE_EN_BIT]))
    else $error("converter enable not stored");

  // forced bypass with closed switch reads as closed
  forced_read_a: assert property (
    (switch_held_s ##0 (forced_bypass_enable ##0 cfg_read_s)) |=>
      sfr_rdata[bcc_pkg::CFG_BYPASS_BIT])
    else $error("closed switch not reported in forced bypass");

  sequence mode_write_s;
    wr_mode;
  endsequence

  sequence mode_read_s;
    rd_mode;
  endsequence

  // two flops from pin to indicator
  bypass_sync_a: assert property (
    bypass_switch_closed [*2] |=> bypass_sync)
    else $error("bypass status not through synchroniser in time");

  vsel_write_a: assert property (
    wr_cfg |=> (output_voltage_select ==
                $past(sfr_req.wdata[bcc_pkg::CFG_VSEL_HI:bcc_pkg::CFG_VSEL_LO])))
    else $error("voltage select not stored");

  osc_hold_a: assert property (
    (!wr_cfg) |=> $stable(oscillator_disable))
    else $error("oscillator disable changed without write");

  cfg_fields_a: assert property (
    cfg_read_s |=> (sfr_rdata[bcc_pkg::CFG_SW_HI:bcc_pkg::CFG_SW_LO] ==
                    $past(switch_size_select)))
    else $error("switch size read back wrong");

  mode_rsv_hi_a: assert property (
    mode_read_s |=> (sfr_rdata[bcc_pkg::MODE_RSV_HI_BIT] == 1'b0) && sfr_rvalid)
    else $error("mode bit 7 does not read zero");

  mode_rsv_lo_a: assert property (
    mode_read_s |=> (sfr_rdata[bcc_pkg::MODE_RSV_LO_BIT] == 1'b1) && sfr_rvalid)
    else $error("mode bit 1 does not read one");

  // only legal limits reach the converter
  ilim_legal_a: assert property (
    (peak_current_limit >= 3'h1) && (peak_current_limit <= 3'h5))
    else $error("reserved current limit reached output");

  ilim_write_a: assert property (
    (wr_mode && (wr_ilim >= 3'h1) && (wr_ilim <= 3'h5)) |=>
      (peak_current_limit == $past(wr_ilim)))
    else $error("current limit not stored");

  ilim_hold_a: assert property (
    (mode_write_s ##0 ((wr_ilim < 3'h1) || (wr_ilim > 3'h5))) |=>
      $stable(peak_current_limit))
    else $error("reserved current limit write changed setting");

  forced_hold_a: assert property (
    (!wr_mode) |=> $stable(forced_bypass_enable))
    else $error("forced bypass changed without write");

  auto_hold_a: assert property (
    (!wr_mode) |=> $stable(automatic_bypass_enable))
    else $error("automatic bypass changed without write");

endmodule

// ===== hw/bcc_sync.sv
// Two-stage synchroniser for the bypass switch status level
`timescale 1ns/1ps
module bcc_sync (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta_ff;
  logic nxt_meta;
  logic sync_ff;
  logic nxt_sync;

  // First stage feeds only the second
  always_comb begin
    nxt_meta = async_in;
    nxt_sync = meta_ff;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign sync_out = sync_ff;

endmodule

// ===== sim/tb_top.sv
// Self-checking bench for the buck converter register bank
`timescale 1ns/1ps
module tb_top;
  logic                     clk;
  logic                     rst;
  bcc_pkg::bcc_sfr_req_type req;
  logic                     byp;
  logic [7:0]               rdata;
  logic                     rvalid;
  logic                     en;
  logic                     forced;
  logic                     autob;
  logic [2:0]               ilim;
  logic [3:0]               vsel;
  logic                     osc_off;
  logic [1:0]               swsel;
  logic [11:0]              mv;
  logic [9:0]               ma;
  int                       n_errors;
  int                       n_checks;
  int                       cyc;

  bcc_regs uut (
    .clk                     (clk),
    .rst                     (rst),
    .sfr_req                 (req),
    .sfr_rdata               (rdata),
    .sfr_rvalid              (rvalid),
    .bypass_switch_closed    (byp),
    .converter_enable        (en),
    .forced_bypass_enable    (forced),
    .automatic_bypass_enable (autob),
    .peak_current_limit      (ilim),
    .output_voltage_select   (vsel),
    .oscillator_disable      (osc_off),
    .switch_size_select      (swsel),
    .target_mv               (mv),
    .current_limit_ma        (ma)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic summarize();
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Called at a falling edge; an idle cycle follows each strobe
  task automatic wr(input logic [7:0] pg, input logic [7:0] a, input logic [7:0] d);
    req = '{page: pg, addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge clk);
    req = '0;
    @(negedge clk);
  endtask

  task automatic rd(input logic [7:0] pg, input logic [7:0] a, input logic [7:0] exp);
    req = '{page: pg, addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(negedge clk);
    req = '0;
    chk(16'(rvalid), 16'h0001);
    chk(16'(rdata), 16'(exp));
    @(negedge clk);
  endtask

  task automatic t_reset();
    chk(16'(mv), 16'h076c);
    chk(16'(ma), 16'h01f4);
    chk(16'({en, forced, autob}), 16'h0000);
    rd(8'h02, 8'hb2, 8'h0b);
    rd(8'h02, 8'hb3, 8'h42);
  endtask

  // Every voltage code, the decoded view a cycle after the field
  task automatic t_vsel();
    logic [11:0] exp;
    for (int c = 0; c < 16; c++) begin
      exp = (c == 15) ? 12'hdac : (c == 14) ? 12'hce4 : 12'(1800 + 100 * c);
      wr(8'h02, 8'hb2, {1'b0, 4'(c), 3'b011});
      chk(16'(vsel), 16'(c));
      @(negedge clk);
      chk(16'(mv), 16'(exp));
      rd(8'h02, 8'hb2, {1'b0, 4'(c), 3'b011});
    end
  endtask

  task automatic t_cfg_bits();
    wr(8'h02, 8'hb2, 8'h85);
    chk(16'({osc_off, swsel}), 16'h0007);
    rd(8'h02, 8'hb2, 8'h07);
    wr(8'h02, 8'hb2, 8'h02);
    chk(16'({osc_off, swsel}), 16'h0003);
    wr(8'h02, 8'hb2, 8'h00);
    chk(16'({osc_off, swsel}), 16'h0000);
  endtask

  // Indicator follows the switch after the two-flop sync
  task automatic t_bypass();
    wr(8'h02, 8'hb3, 8'h4a);
    chk(16'(forced), 16'h0001);
    byp = 1'b1;
    repeat (3) @(negedge clk);
    rd(8'h02, 8'hb2, 8'h80);
    byp = 1'b0;
    repeat (3) @(negedge clk);
    rd(8'h02, 8'hb2, 8'h00);
  endtask

  task automatic t_mode();
    for (int c = 1; c < 6; c++) begin
      wr(8'h02, 8'hb3, {1'b0, 3'(c), 4'b0111});
      chk(16'({ilim, forced, autob, en}), 16'({3'(c), 3'b011}));
      @(negedge clk);
      chk(16'(ma), 16'(100 + 100 * c));
    end
    // Reserved limits keep the last legal code
    for (int k = 0; k < 3; k++) begin
      wr(8'h02, 8'hb3, {1'b0, ((k == 0) ? 3'h0 : 3'(k + 5)), 4'b0010});
      chk(16'(ilim), 16'h0005);
    end
    wr(8'h02, 8'hb3, 8'h00);
    wr(8'h02, 8'hb3, 8'hed);
    @(negedge clk);
    chk(16'(ilim), 16'h0005);
    chk(16'(ma), 16'h0258);
    rd(8'h02, 8'hb3, 8'h5f);
    wr(8'h02, 8'hb3, 8'h72);
    chk(16'({ilim, forced, autob, en}), 16'h0028);
  endtask

  task automatic t_unmapped();
    rd(8'h02, 8'hfd, 8'h00);
    @(negedge clk);
    chk(16'(rvalid), 16'h0000);
    wr(8'h01, 8'hb2, 8'h78);
    wr(8'h02, 8'hb4, 8'h78);
    rd(8'h01, 8'hb3, 8'h00);
    rd(8'h02, 8'hb2, 8'h00);
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_errors++;
      summarize();
    end
  end

  initial begin
    rst = 1'b1;
    req = '0;
    byp = 1'b0;
    n_errors = 0;
    n_checks = 0;
    cyc = 0;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_reset();
    t_vsel();
    t_cfg_bits();
    t_bypass();
    t_mode();
    t_unmapped();
    summarize();
  end
endmodule
